/* File: ieq_cfg_byte.sv */
// one configuration byte with write enable and synchronous reset
module ieq_cfg_byte #(
   parameter logic [7:0] RESET_VAL = ieq_pkg::CFG_RESET
) (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic       wr_en,
   input  wire logic [7:0] wr_data,
   output logic      [7:0] value
);

   logic [7:0] value_reg;
   logic [7:0] value_next;

   // reserved bits are stored as written so software reads them back
   always_comb
   begin
      value_next = value_reg;
      if (wr_en)
      begin
         value_next = wr_data;
      end
   end

   // ************************************************************
   // storage
   // ************************************************************
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         value_reg <= RESET_VAL;
      end
      else
      begin
         value_reg <= value_next;
      end
   end

   assign value = value_reg;

endmodule // ieq_cfg_byte

/* File: ieq_input_eq_polarity_regs.sv */
// input equalizer and polarity register bank for four serial lanes
module ieq_input_eq_polarity_regs (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   // committed accesses from the management interface
   input  wire logic [7:0] mgmt_addr,
   input  wire logic       mgmt_wr_en,
   input  wire logic [7:0] mgmt_wdata,
   input  wire logic       mgmt_rd_en,
   output logic      [7:0] mgmt_rdata,
   output logic            mgmt_rd_valid,
   output logic            mgmt_addr_err,
   // lane 0 controls
   output logic      [1:0] lane0_eq_strength,
   output logic      [3:0] lane0_eq_select,
   output logic            lane0_invert,
   // lane 1 controls
   output logic      [1:0] lane1_eq_strength,
   output logic      [3:0] lane1_eq_select,
   output logic            lane1_invert,
   // lane 2 controls
   output logic      [1:0] lane2_eq_strength,
   output logic      [3:0] lane2_eq_select,
   output logic            lane2_invert,
   // lane 3 controls
   output logic      [1:0] lane3_eq_strength,
   output logic      [3:0] lane3_eq_select,
   output logic            lane3_invert
);

   // ************************************************************
   // declarations
   // ************************************************************
   logic [7:0]       cfg_value [ieq_pkg::NUM_REGS];
   logic [7:0]       cfg_next  [ieq_pkg::NUM_REGS];
   logic             cfg_wr    [ieq_pkg::NUM_REGS];
   logic [1:0]       str_next  [ieq_pkg::NUM_LANES];
   logic             inv_next  [ieq_pkg::NUM_LANES];
   logic [1:0]       str_q     [ieq_pkg::NUM_LANES];
   logic [3:0]       sel_q     [ieq_pkg::NUM_LANES];
   logic             inv_q     [ieq_pkg::NUM_LANES];

   logic             addr_hit;
   logic [7:0]       rd_mux;

   ieq_pkg::ieq_state_t state_reg;
   ieq_pkg::ieq_state_t state_next;
   logic [7:0]       rdata_reg;
   logic [7:0]       rdata_next;
   logic             valid_reg;
   logic             valid_next;
   logic             err_reg;
   logic             err_next;

   // ************************************************************
   // address decode
   // ************************************************************

   // the six bytes sit at consecutive offsets from the first one
   always_comb
   begin
      addr_hit = (mgmt_addr >= ieq_pkg::ADDR_LANE0_EQ)
              && (mgmt_addr <= ieq_pkg::ADDR_LANES23_INV);
   end

   // per-register write strobes; an unmapped write is dropped
   always_comb
   begin
      for (int r = 0; r < ieq_pkg::NUM_REGS; r++)
      begin
         cfg_wr[r] = mgmt_wr_en
                  && (mgmt_addr == (ieq_pkg::ADDR_LANE0_EQ
                                    + 8'(r)));
      end
   end

   // ************************************************************
   // next register contents
   // ************************************************************

   // the lane flops load from these so they move with the bytes
   always_comb
   begin
      for (int r = 0; r < ieq_pkg::NUM_REGS; r++)
      begin
         // write acts next cycle
         // commit to next
         cfg_next[r] = cfg_wr[r] ? mgmt_wdata : cfg_value[r];
      end
   end

   // ************************************************************
   // register storage
   // ************************************************************
   generate
      for (genvar g = 0; g < ieq_pkg::NUM_REGS; g++)
      begin : g_cfg
         ieq_cfg_byte #(
            .RESET_VAL (ieq_pkg::CFG_RESET)
         ) u_byte (
            .sys_clk (sys_clk),
            .rst_n   (rst_n),
            .wr_en   (cfg_wr[g]),
            .wr_data (mgmt_wdata),
            .value   (cfg_value[g])
         );
      end
   endgenerate

   // ************************************************************
   // field extraction per lane
   // ************************************************************

   // lane 0 strength sits two bits higher than the other lanes
   // lane0 bits 5:4
   always_comb
   begin
      str_next[0] = cfg_next[ieq_pkg::EQ_REG[0]]
                    [ieq_pkg::EQ_LSB[0] +: ieq_pkg::EQ_W];
   end

   // lanes one to three share the 3:2 position
   // lane1 bits 3:2
   always_comb
   begin
      str_next[1] = cfg_next[ieq_pkg::EQ_REG[1]]
                    [ieq_pkg::EQ_LSB[1] +: ieq_pkg::EQ_W];
   end

   always_comb
   begin
      str_next[2] = cfg_next[ieq_pkg::EQ_REG[2]]
                    [ieq_pkg::EQ_LSB[2] +: ieq_pkg::EQ_W];
   end

   always_comb
   begin
      str_next[3] = cfg_next[ieq_pkg::EQ_REG[3]]
                    [ieq_pkg::EQ_LSB[3] +: ieq_pkg::EQ_W];
   end

   // inversion bits for lanes zero and one share one byte
   // bits 2 and 5
   always_comb
   begin
      inv_next[0] = cfg_next[ieq_pkg::INV_REG[0]][ieq_pkg::INV_BIT[0]];
      inv_next[1] = cfg_next[ieq_pkg::INV_REG[1]][ieq_pkg::INV_BIT[1]];
   end

   // lanes two and three use the next byte, bits 1 and 5
   // bits 1 and 5
   always_comb
   begin
      inv_next[2] = cfg_next[ieq_pkg::INV_REG[2]][ieq_pkg::INV_BIT[2]];
      inv_next[3] = cfg_next[ieq_pkg::INV_REG[3]][ieq_pkg::INV_BIT[3]];
   end

   // ************************************************************
   // lane control flops
   // ************************************************************
   generate
      for (genvar l = 0; l < ieq_pkg::NUM_LANES; l++)
      begin : g_lane
         ieq_lane_ctrl u_lane (
            .sys_clk       (sys_clk),
            .rst_n         (rst_n),
            .strength_next (str_next[l]),
            .invert_next   (inv_next[l]),
            .strength      (str_q[l]),
            .level_onehot  (sel_q[l]),
            .invert        (inv_q[l])
         );
      end
   endgenerate

   // ************************************************************
   // read path
   // ************************************************************

   // reads see the stored byte, so a same-cycle write is not yet visible
   // read stored byte
   always_comb
   begin
      rd_mux = ieq_pkg::UNMAPPED_DATA;
      for (int r = 0; r < ieq_pkg::NUM_REGS; r++)
      begin
         if (mgmt_addr == (ieq_pkg::ADDR_LANE0_EQ + 8'(r)))
         begin
            rd_mux = cfg_value[r];
         end
      end
   end

   // answer one cycle after the read; back-to-back reads stay in answer
   always_comb
   begin
      state_next = state_reg;
      rdata_next = rdata_reg;
      valid_next = 1'b0;
      err_next   = 1'b0;
      case (state_reg)
         ieq_pkg::ST_IDLE:
         begin
            if (mgmt_rd_en)
            begin
               state_next = ieq_pkg::ST_ANSWER;
               rdata_next = rd_mux;
               valid_next = 1'b1;
            end
         end
         ieq_pkg::ST_ANSWER:
         begin
            if (mgmt_rd_en)
            begin
               rdata_next = rd_mux;
               valid_next = 1'b1;
            end
            else
            begin
               state_next = ieq_pkg::ST_IDLE;
            end
         end
         default:
         begin
            state_next = ieq_pkg::ST_IDLE;
         end
      endcase
      // unmapped access of either kind is flagged for one cycle
      if ((mgmt_rd_en || mgmt_wr_en) && !addr_hit)
      begin
         err_next = 1'b1;
      end
   end

   // ************************************************************
   // read path flops
   // ************************************************************
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state_reg <= ieq_pkg::ST_IDLE;
         rdata_reg <= ieq_pkg::CFG_RESET;
         valid_reg <= 1'b0;
         err_reg   <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         rdata_reg <= rdata_next;
         valid_reg <= valid_next;
         err_reg   <= err_next;
      end
   end

   // ************************************************************
   // outputs, all straight from flops
   // ************************************************************
   assign mgmt_rdata    = rdata_reg;
   assign mgmt_rd_valid = valid_reg;
   assign mgmt_addr_err = err_reg;

   // lane 0
   assign lane0_eq_strength = str_q[0];
   assign lane0_eq_select   = sel_q[0];
   assign lane0_invert      = inv_q[0];

   // lane 1
   assign lane1_eq_strength = str_q[1];
   assign lane1_eq_select   = sel_q[1];
   assign lane1_invert      = inv_q[1];

   // lane 2
   assign lane2_eq_strength = str_q[2];
   assign lane2_eq_select   = sel_q[2];
   assign lane2_invert      = inv_q[2];

   // lane 3
   assign lane3_eq_strength = str_q[3];
   assign lane3_eq_select   = sel_q[3];
   assign lane3_invert      = inv_q[3];

   // reserved bits are not policed: software is trusted to keep them
   // at zero, and whatever it writes is read back unchanged

endmodule // ieq_input_eq_polarity_regs

/* File: ieq_input_eq_polarity_regs_properties.sv */
// ****************************************
// checker on the register bank ports
// ****************************************
module ieq_checker (
   input wire logic       sys_clk,
   input wire logic       rst_n,
   input wire logic [7:0] mgmt_addr,
   input wire logic       mgmt_wr_en,
   input wire logic [7:0] mgmt_wdata,
   input wire logic       mgmt_rd_en,
   input wire logic [7:0] mgmt_rdata,
   input wire logic       mgmt_rd_valid,
   input wire logic       mgmt_addr_err,
   input wire logic [1:0] lane0_eq_strength,
   input wire logic [3:0] lane0_eq_select,
   input wire logic       lane0_invert,
   input wire logic [1:0] lane1_eq_strength,
   input wire logic       lane1_invert,
   input wire logic [1:0] lane2_eq_strength,
   input wire logic       lane2_invert,
   input wire logic [1:0] lane3_eq_strength,
   input wire logic       lane3_invert
);
   timeunit 1ns;
   timeprecision 100ps;

   // all checks share one clock and the synchronous reset
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);

   // write strobe decoded per offset
   logic [5:0] wr_hit;
   assign wr_hit = mgmt_wr_en ? (6'h01 << mgmt_addr[2:0]) & {6{mgmt_addr < 8'h06}} : 6'h00;

   property p_lane0_eq;
      wr_hit[0] |=> lane0_eq_strength == $past(mgmt_wdata[5:4])
         && lane0_eq_select == 4'h1 << $past(mgmt_wdata[5:4]);
   endproperty
   a_lane0_eq: assert property (p_lane0_eq) else $error("lane0 strength wrong");
   property p_lane1_eq;
      wr_hit[1] |=> lane1_eq_strength == $past(mgmt_wdata[3:2]);
   endproperty
   a_lane1_eq: assert property (p_lane1_eq) else $error("lane1 strength wrong");
   property p_lane2_eq;
      wr_hit[2] |=> lane2_eq_strength == $past(mgmt_wdata[3:2]);
   endproperty
   a_lane2_eq: assert property (p_lane2_eq) else $error("lane2 strength wrong");
   property p_lane3_eq;
      wr_hit[3] |=> lane3_eq_strength == $past(mgmt_wdata[3:2]);
   endproperty
   a_lane3_eq: assert property (p_lane3_eq) else $error("lane3 strength wrong");
   property p_inv01;
      wr_hit[4] |=> {lane1_invert, lane0_invert} == {$past(mgmt_wdata[5]), $past(mgmt_wdata[2])};
   endproperty
   a_inv01: assert property (p_inv01) else $error("lane0/1 invert wrong");
   property p_inv23;
      wr_hit[5] |=> {lane3_invert, lane2_invert} == {$past(mgmt_wdata[5]), $past(mgmt_wdata[1])};
   endproperty
   a_inv23: assert property (p_inv23) else $error("lane2/3 invert wrong");
   property p_reset_zero;
      $rose(rst_n) |-> {lane3_eq_strength, lane2_eq_strength, lane1_eq_strength,
         lane0_eq_strength, lane3_invert, lane2_invert, lane1_invert, lane0_invert} == 12'h000
         && lane0_eq_select == 4'h1;
   endproperty
   a_reset_zero: assert property (p_reset_zero) else $error("lanes not cleared");
   property p_inv_hold;
      !wr_hit[4] |=> $stable(lane0_invert) && $stable(lane1_invert);
   endproperty
   a_inv_hold: assert property (p_inv_hold) else $error("invert moved unwritten");
   property p_rd_answer;
      $past(rst_n) |-> mgmt_rd_valid == $past(mgmt_rd_en);
   endproperty
   a_rd_answer: assert property (p_rd_answer) else $error("read answer timing");
   property p_unmapped;
      mgmt_rd_en && mgmt_addr > 8'h05 |=> mgmt_rdata == 8'h00 && mgmt_addr_err;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read answer");

   c_wr_inv: cover property (wr_hit[4]);
   c_rd: cover property (mgmt_rd_valid);
   c_err: cover property (mgmt_addr_err);
endmodule // ieq_checker

bind ieq_input_eq_polarity_regs ieq_checker u_chk (.sys_clk, .rst_n, .mgmt_addr, .mgmt_wr_en,
   .mgmt_wdata, .mgmt_rd_en, .mgmt_rdata, .mgmt_rd_valid, .mgmt_addr_err, .lane0_eq_strength,
   .lane0_eq_select, .lane0_invert, .lane1_eq_strength, .lane1_invert, .lane2_eq_strength,
   .lane2_invert, .lane3_eq_strength, .lane3_invert);

/* File: ieq_input_eq_polarity_regs_tb_top.sv */
module ieq_input_eq_polarity_regs_tb_top;
   timeunit 1ns;
   timeprecision 100ps;

   // ****************************************
   // signals
   // ****************************************
   logic       sys_clk = 1'b0;
   logic       rst_n = 1'b0;
   logic [7:0] mgmt_addr = 8'h00;
   logic       mgmt_wr_en = 1'b0;
   logic [7:0] mgmt_wdata = 8'h00;
   logic       mgmt_rd_en = 1'b0;
   logic [7:0] mgmt_rdata;
   logic       mgmt_rd_valid;
   logic       mgmt_addr_err;
   logic [1:0] eq0, eq1, eq2, eq3;
   logic [3:0] sel0, sel1, sel2, sel3;
   logic       inv0, inv1, inv2, inv3;
   int         n_mismatch = 0;
   int         total_checks = 0;
   int         cycles = 0;

   ieq_input_eq_polarity_regs DUT (.sys_clk(sys_clk), .rst_n(rst_n), .mgmt_addr(mgmt_addr),
      .mgmt_wr_en(mgmt_wr_en), .mgmt_wdata(mgmt_wdata), .mgmt_rd_en(mgmt_rd_en),
      .mgmt_rdata(mgmt_rdata), .mgmt_rd_valid(mgmt_rd_valid), .mgmt_addr_err(mgmt_addr_err),
      .lane0_eq_strength(eq0), .lane0_eq_select(sel0), .lane0_invert(inv0),
      .lane1_eq_strength(eq1), .lane1_eq_select(sel1), .lane1_invert(inv1),
      .lane2_eq_strength(eq2), .lane2_eq_select(sel2), .lane2_invert(inv2),
      .lane3_eq_strength(eq3), .lane3_eq_select(sel3), .lane3_invert(inv3));

   // 8 ns period
   always #4 sys_clk = ~sys_clk;

   // ****************************************
   // tasks
   // ****************************************
   task automatic complete_run;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [11:0] exp, input logic [11:0] got);
      total_checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH %s expected %0h seen %0h", nm, exp, got);
      end
   endtask

   // lane outputs; selects are one-hot of the strength
   task automatic lanes(input logic [7:0] eq, input logic [3:0] inv);
      chk("strength", {4'h0, eq}, {4'h0, eq3, eq2, eq1, eq0});
      chk("invert", {8'h00, inv}, {8'h00, inv3, inv2, inv1, inv0});
      chk("select", {4'h1 << eq[5:4], 4'h1 << eq[3:2], 4'h1 << eq[1:0]},
          {sel2, sel1, sel0});
      chk("select3", {8'h00, 4'h1 << eq[7:6]}, {8'h00, sel3});
   endtask

   // one access; an idle cycle follows so strobes never toggle twice in one step
   task automatic acc(input logic r, input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [7:0] exp);
      mgmt_rd_en = r;
      mgmt_wr_en = w;
      mgmt_addr = a;
      mgmt_wdata = d;
      @(posedge sys_clk);
      #1;
      if (r)
      begin
         chk("rd_valid", 12'h001, {11'h000, mgmt_rd_valid});
         chk("rdata", {4'h0, exp}, {4'h0, mgmt_rdata});
      end
      chk("addr_err", {11'h000, a > 8'h05}, {11'h000, mgmt_addr_err});
      mgmt_rd_en = 1'b0;
      mgmt_wr_en = 1'b0;
      @(posedge sys_clk);
      #1;
      // valid drops after one cycle while the answer byte stays put
      if (r)
      begin
         chk("rd_valid_drop", 12'h000, {11'h000, mgmt_rd_valid});
         chk("rdata_hold", {4'h0, exp}, {4'h0, mgmt_rdata});
      end
   endtask

   task automatic do_reset;
      rst_n = 1'b0;
      repeat (12) @(posedge sys_clk);
      #1;
      rst_n = 1'b1;
   endtask

   // hang guard, far above the roughly one hundred cycles needed
   always @(posedge sys_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_mismatch++;
         complete_run;
      end
   end

   // ****************************************
   // tests
   // ****************************************
   initial
   begin
      do_reset;
      for (int a = 0; a < 6; a++)
         acc(1'b1, 1'b0, 8'(a), 8'h00, 8'h00);
      lanes(8'h00, 4'h0);
      $display("test reset_values done");
      for (int lv = 0; lv < 4; lv++)
      begin
         acc(1'b0, 1'b1, 8'h00, 8'(lv << 4), 8'h00);
         acc(1'b0, 1'b1, 8'h01, 8'(lv << 2), 8'h00);
         acc(1'b0, 1'b1, 8'h02, 8'(lv << 2), 8'h00);
         acc(1'b0, 1'b1, 8'h03, 8'(lv << 2), 8'h00);
         lanes({4{2'(lv)}}, 4'h0);
         acc(1'b1, 1'b0, 8'h00, 8'h00, 8'(lv << 4));
      end
      $display("test eq_levels done");
      acc(1'b0, 1'b1, 8'h04, 8'h24, 8'h00);
      acc(1'b0, 1'b1, 8'h05, 8'h22, 8'h00);
      lanes(8'hFF, 4'hF);
      acc(1'b0, 1'b1, 8'h04, 8'h04, 8'h00);
      acc(1'b0, 1'b1, 8'h05, 8'h20, 8'h00);
      lanes(8'hFF, 4'h9);
      acc(1'b1, 1'b0, 8'h05, 8'h00, 8'h20);
      $display("test invert done");
      acc(1'b1, 1'b1, 8'h04, 8'h20, 8'h04);
      acc(1'b1, 1'b0, 8'h04, 8'h00, 8'h20);
      lanes(8'hFF, 4'hA);
      acc(1'b1, 1'b1, 8'h06, 8'h24, 8'h00);
      acc(1'b1, 1'b0, 8'hFF, 8'h00, 8'h00);
      lanes(8'hFF, 4'hA);
      $display("test access_order done");
      do_reset;
      lanes(8'h00, 4'h0);
      acc(1'b1, 1'b0, 8'h05, 8'h00, 8'h00);
      $display("test second_reset done");
      complete_run;
   end
endmodule // ieq_input_eq_polarity_regs_tb_top

/* File: ieq_lane_ctrl.sv */
// registered controls for one input lane: strength, one-hot level, invert
module ieq_lane_ctrl (
   input  wire logic       sys_clk,
   input  wire logic       rst_n,
   input  wire logic [1:0] strength_next,
   input  wire logic       invert_next,
   output logic      [1:0] strength,
   output logic      [3:0] level_onehot,
   output logic            invert
);

   logic [1:0] strength_reg;
   logic [3:0] onehot_reg;
   logic       invert_reg;
   logic [3:0] onehot_next;

   // decode ahead of the flop so the analog enables never glitch
   always_comb
   begin
      onehot_next = 4'h0;
      case (ieq_pkg::ieq_eq_level_t'(strength_next))
         ieq_pkg::EQ_OFF:    onehot_next = 4'h1;
         ieq_pkg::EQ_SMALL:  onehot_next = 4'h2;
         ieq_pkg::EQ_MEDIUM: onehot_next = 4'h4;
         ieq_pkg::EQ_LARGE:  onehot_next = 4'h8;
         default:            onehot_next = 4'h1;
      endcase
   end

   // ************************************************************
   // lane control flops
   // ************************************************************
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         strength_reg <= ieq_pkg::EQ_OFF;
         onehot_reg   <= 4'h1;
         invert_reg   <= 1'b0;
      end
      else
      begin
         strength_reg <= strength_next;
         onehot_reg   <= onehot_next;
         invert_reg   <= invert_next;
      end
   end

   assign strength     = strength_reg;
   assign level_onehot = onehot_reg;
   assign invert       = invert_reg;

endmodule // ieq_lane_ctrl

/* File: ieq_pkg.sv */
// Functional notes
// - reg 00h bits 5:4 hold lane0 strength
// - reg 01h bits 3:2 hold lane1 strength
// - reg 02h bits 3:2 hold lane2 strength
// - reg 03h bits 3:2 hold lane3 strength
// - reg 04h bit5 lane1, bit2 lane0 invert
// - reg 05h bit5 lane3, bit1 lane2 invert
// - all six registers reset to zero, read/write
package ieq_pkg;

   // ************************************************************
   // sizes
   // ************************************************************
   localparam int NUM_REGS  = 6;
   localparam int NUM_LANES = 4;
   localparam int DATA_W    = 8;
   localparam int ADDR_W    = 8;
   localparam int EQ_W      = 2;
   localparam int LEVELS    = 4;

   // ************************************************************
   // register offsets and reset value
   // ************************************************************
   localparam logic [ADDR_W-1:0] ADDR_LANE0_EQ   = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_LANE1_EQ   = 8'h01;
   localparam logic [ADDR_W-1:0] ADDR_LANE2_EQ   = 8'h02;
   localparam logic [ADDR_W-1:0] ADDR_LANE3_EQ   = 8'h03;
   localparam logic [ADDR_W-1:0] ADDR_LANES01_INV = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_LANES23_INV = 8'h05;
   localparam logic [DATA_W-1:0] CFG_RESET       = 8'h00;
   localparam logic [DATA_W-1:0] UNMAPPED_DATA   = 8'h00;

   // ************************************************************
   // per-lane field layout, indexed by lane number
   // ************************************************************
   localparam int EQ_REG[NUM_LANES]  = '{0, 1, 2, 3};
   localparam int EQ_LSB[NUM_LANES]  = '{4, 2, 2, 2};
   localparam int INV_REG[NUM_LANES] = '{4, 4, 5, 5};
   localparam int INV_BIT[NUM_LANES] = '{2, 5, 1, 5};

   // ************************************************************
   // equalizer strength encoding
   // ************************************************************
   typedef enum logic [EQ_W-1:0] {
      EQ_OFF    = 2'h0,
      EQ_SMALL  = 2'h1,
      EQ_MEDIUM = 2'h2,
      EQ_LARGE  = 2'h3
   } ieq_eq_level_t;

   // ************************************************************
   // read answer state machine
   // ************************************************************
   typedef enum logic [1:0] {
      ST_IDLE   = 2'h1,
      ST_ANSWER = 2'h2
   } ieq_state_t;

endpackage : ieq_pkg
